/* ptr_rate_sum_regs.sv */
// Purpose: Timing register bank: rate control, page checksums, stamp ports
// Assumes: One register access per cycle, inputs synchronous to core_clk
// Notes: Read data appear one cycle after the read strobe
`timescale 1ns/1ps
module ptr_rate_sum_regs
	import ptr_pkg::*;
#(
	parameter logic [NS_W-1:0] REF_PERIOD_NS = 30'h0000_0008,
	parameter int DUR_W = 16,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [REG_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_ctrl_frame,
	output logic [REG_W-1:0] reg_rdata_q,
	output logic reg_rvalid_q,
	input wire logic [DUR_W-1:0] temporary_rate_duration,
	input wire logic tx_stamp_valid,
	input wire logic [NS_W-1:0] tx_stamp_ns,
	input wire logic [SEC_W-1:0] tx_stamp_sec,
	output logic tx_stamp_ready,
	input wire logic rx_stamp_valid,
	input wire logic [NS_W-1:0] rx_stamp_ns,
	input wire logic [SEC_W-1:0] rx_stamp_sec,
	input wire logic [15:0] rx_sequence_id,
	input wire logic [3:0] rx_message_type,
	input wire logic [11:0] rx_source_hash,
	output logic rx_stamp_ready,
	output logic [SEC_W-1:0] tod_sec_q,
	output logic [NS_W-1:0] tod_ns_q,
	output logic transmit_stamp_irq_enable_q,
	output logic receive_stamp_irq_enable_q
);
	localparam int FINE_W = NS_W + FRAC_W;
	localparam logic [FINE_W-1:0] NOMINAL_STEP = {REF_PERIOD_NS, FRAC_ZERO};
	localparam logic [FINE_W-1:0] SEC_FINE = {NS_PER_SEC, FRAC_ZERO};

	function automatic logic [REG_W-1:0] ones_add(input logic [REG_W-1:0] a,
		input logic [REG_W-1:0] b);
		logic [REG_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[REG_W-1:0] + {{(REG_W-1){1'b0}}, s[REG_W]};
	endfunction

	function automatic logic [REG_W-1:0] stamp_word(input logic [STAMP_W-1:0] e,
		input logic [IDX_W-1:0] idx);
		logic [REG_W-1:0] w;
		w = REG_RESET;
		unique case (idx)
			3'h0: w = e[15:0];
			3'h1: w = {e[STAMP_W-1 -: DROP_W], e[NS_W-1:16]};
			3'h2: w = e[NS_W+15:NS_W];
			3'h3: w = e[NS_W+SEC_W-1:NS_W+16];
			default: w = REG_RESET;
		endcase
		return w;
	endfunction

	logic [RATE_W-1:0] rate_mag_q;
	logic rate_slow_q;
	logic rate_on_q;
	logic temp_q;
	logic [DUR_W-1:0] temp_left_q;
	logic rate_sign_q;
	logic temporary_rate_select_q;
	logic [RATE_HIGH_MSB:0] rate_high_bits_q;
	logic [FINE_W-1:0] tod_fine;
	logic [FINE_W-1:0] tod_next;
	logic [FRAC_W-1:0] tod_frac_q;
	logic [REG_W-1:0] read_sum_value_q;
	logic [REG_W-1:0] write_sum_value_q;
	logic [REG_W-1:0] rd_word;
	logic [DROP_W-1:0] tx_drop_q;
	logic [DROP_W-1:0] rx_drop_q;
	logic [IDX_W-1:0] tx_idx_q;
	logic [IDX_W-1:0] rx_idx_q;
	logic tx_out_valid;
	logic rx_out_valid;
	logic [STAMP_W-1:0] tx_entry;
	logic [STAMP_W+RX_EXTRA_W-1:0] rx_entry;
	logic tx_pop;
	logic rx_pop;
	logic low_load;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// Stamp queues with drop count stored per entry
	ptr_stamp_fifo #(.WIDTH(STAMP_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(tx_stamp_valid),
		.in_ready(tx_stamp_ready),
		.in_data({tx_drop_q, tx_stamp_sec, tx_stamp_ns}),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_entry)
	);

	ptr_stamp_fifo #(.WIDTH(STAMP_W + RX_EXTRA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(rx_stamp_valid),
		.in_ready(rx_stamp_ready),
		.in_data({rx_message_type, rx_source_hash, rx_sequence_id, rx_drop_q,
			rx_stamp_sec, rx_stamp_ns}),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_entry)
	);

	assign low_load = reg_wr && (reg_addr == ADDR_RATE_LOW);
	assign tx_pop = reg_rd && (reg_addr == ADDR_TX_PORT) && tx_out_valid
		&& (tx_idx_q == TX_LAST_WORD);
	assign rx_pop = reg_rd && (reg_addr == ADDR_RX_PORT) && rx_out_valid
		&& (rx_idx_q == RX_LAST_WORD);

	// Read data decode
	always_comb begin
		rd_word = REG_RESET;
		unique case (reg_addr)
			ADDR_IRQ_EN: begin
				rd_word[TX_IRQ_EN_BIT] = transmit_stamp_irq_enable_q;
				rd_word[RX_IRQ_EN_BIT] = receive_stamp_irq_enable_q;
			end
			ADDR_RATE_LOW: rd_word = rate_mag_q[REG_W-1:0];
			ADDR_RATE_HIGH: begin
				rd_word[RATE_SIGN_BIT] = rate_sign_q;
				rd_word[TEMP_SEL_BIT] = temporary_rate_select_q;
				rd_word[RATE_HIGH_MSB:0] = rate_high_bits_q;
			end
			ADDR_READ_SUM: rd_word = read_sum_value_q;
			ADDR_WRITE_SUM: rd_word = write_sum_value_q;
			ADDR_TX_PORT: begin
				if (tx_out_valid) begin
					rd_word = stamp_word(tx_entry, tx_idx_q);
				end
			end
			ADDR_RX_PORT: begin
				if (rx_out_valid) begin
					unique case (rx_idx_q)
						3'h4: rd_word = rx_entry[STAMP_W+15:STAMP_W];
						3'h5: rd_word = rx_entry[STAMP_W+31:STAMP_W+16];
						default: rd_word = stamp_word(rx_entry[STAMP_W-1:0], rx_idx_q);
					endcase
				end
			end
			default: rd_word = REG_RESET;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata_q <= REG_RESET;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd;
			if (reg_rd) begin
				reg_rdata_q <= rd_word;
			end
		end
	end

	// Software fields of the rate and enable registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rate_sign_q <= 1'b0;
			temporary_rate_select_q <= 1'b0;
			rate_high_bits_q <= '0;
			transmit_stamp_irq_enable_q <= 1'b0;
			receive_stamp_irq_enable_q <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_RATE_HIGH) begin
				rate_sign_q <= reg_wdata[RATE_SIGN_BIT];
				temporary_rate_select_q <= reg_wdata[TEMP_SEL_BIT];
				rate_high_bits_q <= reg_wdata[RATE_HIGH_MSB:0];
			end
			if (reg_addr == ADDR_IRQ_EN) begin
				transmit_stamp_irq_enable_q <= reg_wdata[TX_IRQ_EN_BIT];
				receive_stamp_irq_enable_q <= reg_wdata[RX_IRQ_EN_BIT];
			end
		end
	end

	// Active rate loaded by low write, temporary interval countdown
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rate_mag_q <= '0;
			rate_slow_q <= 1'b0;
			rate_on_q <= 1'b0;
			temp_q <= 1'b0;
			temp_left_q <= '0;
		end else if (low_load) begin
			rate_mag_q <= {rate_high_bits_q, reg_wdata};
			rate_slow_q <= rate_sign_q;
			temp_q <= temporary_rate_select_q;
			temp_left_q <= temporary_rate_duration;
			rate_on_q <= !temporary_rate_select_q || (temporary_rate_duration != '0);
		end else if (temp_q && rate_on_q) begin
			temp_left_q <= temp_left_q - 1'b1;
			if (temp_left_q == {{(DUR_W-1){1'b0}}, 1'b1}) begin
				rate_on_q <= 1'b0;
				temp_q <= 1'b0;
			end
		end
	end

	// Time-of-day clock in 2^-32 ns steps
	assign tod_fine = {tod_ns_q, tod_frac_q};
	always_comb begin
		tod_next = tod_fine + NOMINAL_STEP;
		if (rate_on_q) begin
			if (rate_slow_q) begin
				tod_next = tod_fine + NOMINAL_STEP - FINE_W'(rate_mag_q);
			end else begin
				tod_next = tod_fine + NOMINAL_STEP + FINE_W'(rate_mag_q);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tod_ns_q <= '0;
			tod_frac_q <= FRAC_ZERO;
			tod_sec_q <= '0;
		end else if (tod_next >= SEC_FINE) begin
			{tod_ns_q, tod_frac_q} <= tod_next - SEC_FINE;
			tod_sec_q <= tod_sec_q + 1'b1;
		end else begin
			{tod_ns_q, tod_frac_q} <= tod_next;
		end
	end

	// Page read checksum
	always_ff @(posedge core_clk) begin
		if (rst) begin
			read_sum_value_q <= REG_RESET;
		end else if (reg_rd && (reg_addr == ADDR_READ_SUM)) begin
			read_sum_value_q <= REG_RESET;
		end else if (reg_rd && !reg_ctrl_frame) begin
			read_sum_value_q <= ones_add(read_sum_value_q, rd_word);
		end
	end

	// Page write checksum
	always_ff @(posedge core_clk) begin
		if (rst) begin
			write_sum_value_q <= REG_RESET;
		end else if (reg_rd && (reg_addr == ADDR_WRITE_SUM)) begin
			write_sum_value_q <= REG_RESET;
		end else if (reg_wr && !reg_ctrl_frame) begin
			write_sum_value_q <= ones_add(write_sum_value_q, reg_wdata);
		end
	end

	// Drop counters, cleared when carried into a stored entry
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_drop_q <= '0;
			rx_drop_q <= '0;
		end else begin
			if (tx_stamp_valid && tx_stamp_ready) begin
				tx_drop_q <= '0;
			end else if (tx_stamp_valid && tx_drop_q != DROP_MAX) begin
				tx_drop_q <= tx_drop_q + 1'b1;
			end
			if (rx_stamp_valid && rx_stamp_ready) begin
				rx_drop_q <= '0;
			end else if (rx_stamp_valid && rx_drop_q != DROP_MAX) begin
				rx_drop_q <= rx_drop_q + 1'b1;
			end
		end
	end

	// Word position within the entry at each port
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_idx_q <= '0;
			rx_idx_q <= '0;
		end else begin
			if (tx_pop) begin
				tx_idx_q <= '0;
			end else if (reg_rd && (reg_addr == ADDR_TX_PORT) && tx_out_valid) begin
				tx_idx_q <= tx_idx_q + 1'b1;
			end
			if (rx_pop) begin
				rx_idx_q <= '0;
			end else if (reg_rd && (reg_addr == ADDR_RX_PORT) && rx_out_valid) begin
				rx_idx_q <= rx_idx_q + 1'b1;
			end
		end
	end

	a_rate_load_full: assert property (
		low_load |=> rate_mag_q == {$past(rate_high_bits_q), $past(reg_wdata)})
		else $error("rate not loaded on low write");
	a_high_reserved_zero: assert property (
		reg_rd && reg_addr == ADDR_RATE_HIGH |=> reg_rvalid_q && reg_rdata_q[13:10] == 4'h0)
		else $error("reserved rate bits not zero");
	a_slow_step_sub: assert property (
		rate_on_q && rate_slow_q && !low_load && tod_next < SEC_FINE
		|=> tod_fine == $past(tod_fine) + NOMINAL_STEP - FINE_W'($past(rate_mag_q)))
		else $error("slow rate step wrong");
	a_nominal_step: assert property (
		!rate_on_q && tod_next < SEC_FINE |=> tod_ns_q == $past(tod_ns_q) + REF_PERIOD_NS
		&& tod_frac_q == $past(tod_frac_q))
		else $error("nominal step wrong");
	a_temp_expire: assert property (
		temp_q && rate_on_q && !low_load && temp_left_q == {{(DUR_W-1){1'b0}}, 1'b1}
		|=> !rate_on_q ##1 !rate_on_q || $past(low_load))
		else $error("temporary rate did not end");
	a_read_sum_clear: assert property (
		reg_rd && reg_addr == ADDR_READ_SUM |=> read_sum_value_q == REG_RESET)
		else $error("read checksum not cleared");
	a_ctrl_no_sum: assert property (
		reg_wr && reg_ctrl_frame |=> $stable(write_sum_value_q))
		else $error("control frame write accumulated");
	a_write_sum_cross: assert property (
		reg_rd && !reg_ctrl_frame && reg_addr == ADDR_WRITE_SUM
		|=> read_sum_value_q == ones_add($past(read_sum_value_q), $past(write_sum_value_q))
		&& write_sum_value_q == REG_RESET)
		else $error("write checksum read not cross summed");
	a_drop_saturate: assert property (
		tx_drop_q == DROP_MAX && !(tx_stamp_valid && tx_stamp_ready) |=> tx_drop_q == DROP_MAX)
		else $error("drop count left saturation");
	a_tx_entry_advance: assert property (
		tx_pop |=> tx_idx_q == '0 ##0 reg_rdata_q == $past(stamp_word(tx_entry, TX_LAST_WORD)))
		else $error("transmit entry not advanced");
endmodule // ptr_rate_sum_regs

/* ptr_pkg.sv */
// Purpose: Shared constants for the timing register bank
// Assumes: 16-bit management registers, 5-bit register address
// Notes: Register offsets, field positions, reset values, last word index of each queue entry
package ptr_pkg;
	localparam int REG_W = 16;
	localparam int ADDR_W = 5;
	localparam int RATE_W = 26;
	localparam int NS_W = 30;
	localparam int SEC_W = 32;
	localparam int FRAC_W = 32;
	localparam int DROP_W = 2;
	localparam int STAMP_W = DROP_W + SEC_W + NS_W;
	localparam int RX_EXTRA_W = 32;
	localparam int IDX_W = 3;

	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 5'h16;
	localparam logic [ADDR_W-1:0] ADDR_RATE_LOW = 5'h18;
	localparam logic [ADDR_W-1:0] ADDR_RATE_HIGH = 5'h19;
	localparam logic [ADDR_W-1:0] ADDR_READ_SUM = 5'h1A;
	localparam logic [ADDR_W-1:0] ADDR_WRITE_SUM = 5'h1B;
	localparam logic [ADDR_W-1:0] ADDR_TX_PORT = 5'h1C;
	localparam logic [ADDR_W-1:0] ADDR_RX_PORT = 5'h1D;

	localparam int RATE_SIGN_BIT = 15;
	localparam int TEMP_SEL_BIT = 14;
	localparam int RATE_HIGH_MSB = 9;
	localparam int TX_IRQ_EN_BIT = 3;
	localparam int RX_IRQ_EN_BIT = 2;

	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	localparam logic [DROP_W-1:0] DROP_MAX = 2'h3;
	localparam logic [IDX_W-1:0] TX_LAST_WORD = 3'h3;
	localparam logic [IDX_W-1:0] RX_LAST_WORD = 3'h5;
	localparam logic [NS_W-1:0] NS_PER_SEC = 30'h3B9A_CA00;
	localparam logic [FRAC_W-1:0] FRAC_ZERO = 32'h0000_0000;
endpackage

/* ptr_stamp_fifo.sv */
// Purpose: Small first-word-fall-through queue for timestamp entries
// Assumes: One push and one pop per cycle at most on each side
// Notes: Ready and valid come from flops
`timescale 1ns/1ps
module ptr_stamp_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [PTR_W:0] count_q;
	logic [PTR_W:0] count_d;
	logic empty_q;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_ready && !empty_q;
	assign out_valid = !empty_q;
	assign out_data = mem_q[rd_ptr_q];

	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			in_ready <= 1'b1;
			empty_q <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_d;
			in_ready <= (count_d != FULL_CNT);
			empty_q <= (count_d == '0);
		end
	end
endmodule // ptr_stamp_fifo

/* ptr_host_model.sv */
// Purpose: Management host model for the timing register bank
// Assumes: Strobes launched 1 ns after the clock edge
// Notes: Address and data inverted once released
`timescale 1ns/1ps
module ptr_host_model
	import ptr_pkg::*;
(
	input wire logic core_clk,
	output logic [ADDR_W-1:0] reg_addr,
	output logic [REG_W-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic reg_ctrl_frame,
	input wire logic [REG_W-1:0] reg_rdata_q,
	input wire logic reg_rvalid_q
);
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_ctrl_frame = 1'b0;
	end

	// One access; read data taken the cycle after the strobe
	task automatic acc(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
		input logic w, input logic c, output logic [REG_W-1:0] q);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		reg_ctrl_frame = c;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_ctrl_frame = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		q = 'x;
		if (!w && reg_rvalid_q === 1'b1) begin
			q = reg_rdata_q;
		end
	endtask

	// High half first, low half loads the rate
	task automatic set_rate(input logic [REG_W-1:0] h, input logic [REG_W-1:0] l);
		logic [REG_W-1:0] q;
		acc(ADDR_RATE_HIGH, h, 1'b1, 1'b0, q);
		acc(ADDR_RATE_LOW, l, 1'b1, 1'b0, q);
	endtask
endmodule // ptr_host_model

/* tb.sv */
// Purpose: Self-checking bench for the timing register bank
// Assumes: Default nominal period of 8 ns
// Notes: Rate checks allow one count of fraction slack, the temporary rate check two
`timescale 1ns/1ps
module tb;
	import ptr_pkg::*;
	logic core_clk, rst, reg_wr, reg_rd, reg_ctrl_frame, reg_rvalid_q;
	logic [ADDR_W-1:0] reg_addr;
	logic [REG_W-1:0] reg_wdata, reg_rdata_q, q;
	logic [15:0] dur;
	logic tx_valid, tx_ready, rx_valid, rx_ready, tx_ie, rx_ie;
	logic [NS_W-1:0] st_ns, tod_ns;
	logic [SEC_W-1:0] st_sec, tod_sec;
	logic [15:0] seq;
	logic [3:0] mtype;
	logic [11:0] hash;
	int failures, comparisons;

	ptr_host_model host(.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ctrl_frame(reg_ctrl_frame),
		.reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));
	ptr_rate_sum_regs dut(.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_ctrl_frame(reg_ctrl_frame), .reg_rdata_q(reg_rdata_q),
		.reg_rvalid_q(reg_rvalid_q), .temporary_rate_duration(dur),
		.tx_stamp_valid(tx_valid), .tx_stamp_ns(st_ns), .tx_stamp_sec(st_sec),
		.tx_stamp_ready(tx_ready), .rx_stamp_valid(rx_valid), .rx_stamp_ns(st_ns),
		.rx_stamp_sec(st_sec), .rx_sequence_id(seq), .rx_message_type(mtype),
		.rx_source_hash(hash), .rx_stamp_ready(rx_ready), .tod_sec_q(tod_sec),
		.tod_ns_q(tod_ns), .transmit_stamp_irq_enable_q(tx_ie),
		.receive_stamp_irq_enable_q(rx_ie));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic summarize();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic c, input logic [15:0] e);
		logic [15:0] r;
		host.acc(a, 16'h0000, 1'b0, c, r);
		check({16'h0000, r}, {16'h0000, e}, "read data");
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic c);
		host.acc(a, d, 1'b1, c, q);
	endtask

	task automatic meas(input int n, input int lo, input int hi);
		logic [NS_W-1:0] t0;
		logic [31:0] d;
		t0 = tod_ns;
		repeat (n) @(posedge core_clk);
		#1;
		d = 32'(tod_ns - t0);
		check({31'h0000_0000, (d >= lo && d <= hi)}, 32'h0000_0001, "clock step");
	endtask

	task automatic push(input logic rx, input int i);
		@(posedge core_clk);
		#1;
		check({31'h0000_0000, rx ? rx_ready : tx_ready}, 32'h0000_0001, "ready");
		tx_valid = !rx;
		rx_valid = rx;
		st_ns = 30'h1234_5600 | 30'(i);
		st_sec = 32'h8765_4300 | 32'(i);
		seq = 16'hC000 | 16'(i);
		hash = 12'h5A0 | 12'(i);
		@(posedge core_clk);
		#1;
		tx_valid = 1'b0;
		rx_valid = 1'b0;
		st_ns = ~st_ns;
		st_sec = ~st_sec;
	endtask

	task automatic pop(input logic rx, input int i, input logic [1:0] drop);
		logic [15:0] w [6];
		logic [29:0] ns;
		logic [31:0] sec;
		ns = 30'h1234_5600 | 30'(i);
		sec = 32'h8765_4300 | 32'(i);
		w[0] = ns[15:0];
		w[1] = {drop, ns[29:16]};
		w[2] = sec[15:0];
		w[3] = sec[31:16];
		w[4] = 16'hC000 | 16'(i);
		w[5] = {4'h9, 12'h5A0 | 12'(i)};
		for (int k = 0; k < (rx ? 6 : 4); k++) begin
			rdc(rx ? ADDR_RX_PORT : ADDR_TX_PORT, 1'b0, w[k]);
		end
	endtask

	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		summarize();
	end

	initial begin
		rst = 1'b1;
		dur = 16'h00C8;
		tx_valid = 1'b0;
		rx_valid = 1'b0;
		st_ns = '0;
		st_sec = '0;
		seq = 16'h0000;
		mtype = 4'h9;
		hash = 12'h000;
		repeat (16) @(posedge core_clk);
		#1;
		rst = 1'b0;
		// Reset values and enables
		rdc(ADDR_RATE_LOW, 1'b0, 16'h0000);
		rdc(ADDR_TX_PORT, 1'b0, 16'h0000);
		rdc(ADDR_RX_PORT, 1'b0, 16'h0000);
		rdc(ADDR_IRQ_EN, 1'b0, 16'h0000);
		wr(ADDR_IRQ_EN, 16'hFFFF, 1'b0);
		rdc(ADDR_IRQ_EN, 1'b0, 16'h000C);
		check({30'h0000_0000, tx_ie, rx_ie}, 32'h0000_0003, "enables");
		wr(5'h05, 16'h5555, 1'b0);
		rdc(5'h05, 1'b0, 16'h0000);
		// Checksums, cleared by control-frame reads first
		host.acc(ADDR_READ_SUM, 16'h0000, 1'b0, 1'b1, q);
		host.acc(ADDR_WRITE_SUM, 16'h0000, 1'b0, 1'b1, q);
		wr(ADDR_RATE_HIGH, 16'hFFFF, 1'b0);
		wr(ADDR_READ_SUM, 16'h0002, 1'b0);
		wr(ADDR_IRQ_EN, 16'h1234, 1'b1);
		rdc(ADDR_RATE_HIGH, 1'b0, 16'hC3FF);
		rdc(ADDR_WRITE_SUM, 1'b0, 16'h0002);
		rdc(ADDR_WRITE_SUM, 1'b0, 16'h0000);
		rdc(ADDR_IRQ_EN, 1'b1, 16'h0004);
		rdc(ADDR_READ_SUM, 1'b0, 16'hC401);
		rdc(ADDR_READ_SUM, 1'b0, 16'h0000);
		// Rate: high write alone loads nothing
		meas(100, 800, 800);
		host.set_rate(16'h03FF, 16'hFFFF);
		rdc(ADDR_RATE_LOW, 1'b0, 16'hFFFF);
		meas(1000, 8015, 8016);
		wr(ADDR_RATE_HIGH, 16'h83FF, 1'b0);
		meas(1000, 8015, 8016);
		wr(ADDR_RATE_LOW, 16'hFFFF, 1'b0);
		meas(1000, 7984, 7985);
		host.set_rate(16'h43FF, 16'hFFFF);
		meas(1000, 8002, 8004);
		// Transmit queue: fill, drop five, drain
		for (int i = 1; i <= 4; i++) begin
			push(1'b0, i);
		end
		@(posedge core_clk);
		#1;
		check({31'h0000_0000, tx_ready}, 32'h0000_0000, "full");
		tx_valid = 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		tx_valid = 1'b0;
		pop(1'b0, 1, 2'h0);
		push(1'b0, 5);
		for (int i = 2; i <= 4; i++) begin
			pop(1'b0, i, 2'h0);
		end
		pop(1'b0, 5, DROP_MAX);
		rdc(ADDR_TX_PORT, 1'b0, 16'h0000);
		// Receive queue
		push(1'b1, 1);
		push(1'b1, 2);
		pop(1'b1, 1, 2'h0);
		pop(1'b1, 2, 2'h0);
		rdc(ADDR_RX_PORT, 1'b0, 16'h0000);
		check(tod_sec, 32'h0000_0000, "seconds");
		summarize();
	end
endmodule // tb
